// [rtcsf_pkg.sv]
// constants, register map and carrier types of the rtc supervisor status flags block
package rtcsf_pkg;
  // clock and timing
  localparam int unsigned MCLK_HZ        = 25_000_000;
  localparam int unsigned TREC_DEF_MS    = 96;      // tr=0, halt=0 (least of 96..98 ms)
  localparam int unsigned TREC_HALT_MS   = 40;      // tr=0, halt=1 (least of 40..200 ms)
  localparam int unsigned TREC_FAST_US   = 50;      // tr=1 (least of 50..2000 us)
  localparam int unsigned BAT_PERIOD_H   = 24;      // battery recheck interval
  localparam int unsigned TREC_DEF_CYC   = TREC_DEF_MS * (MCLK_HZ / 1_000);
  localparam int unsigned TREC_HALT_CYC  = TREC_HALT_MS * (MCLK_HZ / 1_000);
  localparam int unsigned TREC_FAST_CYC  = TREC_FAST_US * (MCLK_HZ / 1_000_000);
  localparam longint unsigned BAT_PERIOD_CYC = 64'(BAT_PERIOD_H) * 64'd3600 * 64'(MCLK_HZ);
  localparam int unsigned DESEL_W        = 22;
  localparam int unsigned BAT_W          = 42;
  // serial bus
  localparam logic [6:0] DEV_ADDR        = 7'h68;   // bus address, arbitrary
  localparam logic [63:0] SERIAL_DEF     = 64'h5a3c_e1f0_0f1e_c3a5; // arbitrary, unique per part
  // register offsets
  localparam logic [7:0] REG_HALT        = 8'h01;
  localparam logic [7:0] REG_HOURS       = 8'h04;
  localparam logic [7:0] REG_CTRL        = 8'h08;
  localparam logic [7:0] REG_WDOG        = 8'h09;
  localparam logic [7:0] REG_ALARM       = 8'h0a;
  localparam logic [7:0] REG_FREEZE      = 8'h0c;
  localparam logic [7:0] REG_FLAGS       = 8'h0f;
  localparam logic [7:0] REG_IRQCFG      = 8'h13;
  localparam logic [7:0] REG_TAMPER      = 8'h14;
  localparam logic [7:0] REG_TAMPER2     = 8'h15;
  localparam logic [7:0] REG_SERIAL      = 8'h18;   // 8 bytes, 18h..1fh
  // field positions
  localparam int unsigned BIT_HALT       = 7;
  localparam int unsigned BIT_TR         = 7;
  localparam int unsigned BIT_OUT        = 7;
  localparam int unsigned BIT_FT         = 6;
  localparam int unsigned BIT_AFE        = 7;
  localparam int unsigned BIT_SQ_WAVE_EN       = 6;
  localparam int unsigned BIT_ABE        = 5;
  localparam int unsigned BIT_HT         = 6;
  localparam int unsigned BIT_BL         = 4;
  localparam int unsigned BIT_OF         = 2;
  localparam int unsigned BIT_OSC_FAIL_IRQ_EN       = 7;
  localparam int unsigned BIT_SQ_WAVE_OPEN_DRAIN      = 1;
  localparam int unsigned BIT_PF_OUT_OPEN_DRAIN       = 0;
  localparam int unsigned BIT_F32K       = 7;
  localparam int unsigned BIT_THS        = 6;
  // pins sampled from outside the clock domain
  typedef struct packed {
    logic vcc_ok;
    logic bat_low;
    logic osc_run;
    logic scl;
    logic sda;
  } rtcsf_pins_t;
  localparam rtcsf_pins_t PINS_RST = '{vcc_ok: 1'b0, bat_low: 1'b0, osc_run: 1'b0, scl: 1'b1, sda: 1'b1};
  // battery-backed control bits
  typedef struct packed {
    logic       halt;
    logic [6:0] halt_lo;
    logic       tr;
    logic [6:0] hours_lo;
    logic       osc_fail_irq_en;
    logic       ht;
    logic       pin_level;
    logic       ft;
    logic       afe;
    logic       abe;
    logic       sq_wave_en;
    logic       sq_wave_open_drain;
    logic       pf_out_open_drain;
    logic [7:0] wdog;
    logic       f32k;
    logic       threshold_select;
    logic [1:0] teb;
    logic [1:0] tie;
    logic [1:0] tclr;
    logic [7:0] tmisc;
  } rtcsf_ctrl_t;
  localparam rtcsf_ctrl_t CTRL_INIT = '{halt: 1'b0, halt_lo: 7'h00, tr: 1'b0, hours_lo: 7'h00, osc_fail_irq_en: 1'b0,
    ht: 1'b1, pin_level: 1'b1, ft: 1'b0, afe: 1'b0, abe: 1'b0, sq_wave_en: 1'b0, sq_wave_open_drain: 1'b1, pf_out_open_drain: 1'b1,
    wdog: 8'h00, f32k: 1'b1, threshold_select: 1'b0, teb: 2'h0, tie: 2'h0, tclr: 2'h0, tmisc: 8'h00};
endpackage : rtcsf_pkg

// [rtcsf_sync.sv]
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module rtcsf_sync #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST;
      q    <= RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rtcsf_sync
`default_nettype wire

// [rtcsf_timer.sv]
// loadable down-counter giving a busy level and an end pulse
`timescale 1ns/1ps
`default_nettype none
module rtcsf_timer #(
  parameter int unsigned W = 22
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         abort,
  // status
  output logic              busy,
  output logic              done
);
  logic [W-1:0] count;

  // busy stays high for load_val cycles after the load edge; abort wins over load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy  <= 1'b0;
        count <= '0;
      end else if (load) begin
        busy  <= 1'b1;
        count <= load_val;
      end else if (busy) begin
        if (count <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule : rtcsf_timer
`default_nettype wire

// [rtcsf_top.sv]
// rtc supervisor status flags: power sequencing, battery and oscillator flags, serial registers
// Summary of operation
// - check battery at power-up and every 24 hours
// - failed check sets battery_low_flag, flags bit 4
// - battery_low_flag stays until a check passes
// - no battery checks while on backup battery
// - recovery_time_select is bit 7 of 04h
// - deselect length from select and halt bits
// - stay deselected, refusing writes, after supply returns
// - eight-byte serial number, read only
// - osc_fail_flag sets whenever the oscillator stops
// - enabled osc_fail_flag pulls interrupt_pin low
// - interrupt clears by writes or reset, not reads
// - stop detection works on main and battery
// - on battery, pin driven only with backup_alarm_en
// - initial power-up defaults for flag and control bits
// - later power-ups keep or clear listed bits
// - tamper and 32k controls defaults and retention
// - tamper enabled blocks update_freeze_flag at power-down
// - unlisted control bits have no promised start value
// - no source enabled: pin follows pin_level_bit
`timescale 1ns/1ps
`default_nettype none
module rtcsf_top
  import rtcsf_pkg::*;
#(
  parameter logic [DESEL_W-1:0] TREC_DEF_CYC_P  = DESEL_W'(TREC_DEF_CYC),
  parameter logic [DESEL_W-1:0] TREC_HALT_CYC_P = DESEL_W'(TREC_HALT_CYC),
  parameter logic [BAT_W-1:0]   BAT_CYC_P       = BAT_W'(BAT_PERIOD_CYC),
  parameter logic [63:0]        SERIAL          = SERIAL_DEF
) (
  // clock and battery-first reset
  input  wire logic mclk,
  input  wire logic resetn,
  // supply and oscillator monitors
  input  wire logic vcc_ok_pin,
  input  wire logic bat_low_pin,
  input  wire logic osc_run_pin,
  // two-wire serial bus
  input  wire logic scl_pin,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // open-drain interrupt and reset outputs
  output logic      irq_n_out,
  output logic      irq_n_oe,
  output logic      rst_n_out,
  output logic      rst_n_oe
);
  typedef enum logic [3:0] {S_IDLE, S_DEV, S_DEV_ACK, S_PTR, S_PTR_ACK, S_WDAT, S_WDAT_ACK,
                            S_RDAT, S_RDAT_ACK} rtcsf_state_t;

  rtcsf_pins_t        pins_raw;
  rtcsf_pins_t        pins_s;
  rtcsf_ctrl_t        ctrl;
  rtcsf_state_t       state;
  logic               vcc_q;
  logic               vcc_rise;
  logic               vcc_fall;
  logic               scl_q;
  logic               sda_q;
  logic               scl_rise;
  logic               scl_fall;
  logic               bus_start;
  logic               bus_stop;
  logic               osc_fail_flag;
  logic               battery_low_flag;
  logic               bat_check;
  logic               bat_done;
  logic               desel_busy;
  logic [DESEL_W-1:0] desel_val;
  logic [7:0]         shreg;
  logic [7:0]         rdreg;
  logic [7:0]         ptr;
  logic [2:0]         bitcnt;
  logic               ack_on;
  logic               reg_wr;
  logic [7:0]         wr_ptr;
  logic [7:0]         wr_data;
  logic               any_src;
  logic               irq_src;
  logic               pin_low;
  logic [7:0]         rd_now;

  assign pins_raw = '{vcc_ok: vcc_ok_pin, bat_low: bat_low_pin, osc_run: osc_run_pin, scl: scl_pin, sda: sda_in};

  rtcsf_sync #(
    .W   ($bits(rtcsf_pins_t)),
    .RST (PINS_RST)
  ) u_sync (
    .clk    (mclk),
    .resetn (resetn),
    .d      (pins_raw),
    .q      (pins_s)
  );

  // supply edges; a rise after reset is the initial power-up
  assign vcc_rise  = pins_s.vcc_ok & ~vcc_q;
  assign vcc_fall  = ~pins_s.vcc_ok & vcc_q;
  assign scl_rise  = pins_s.scl & ~scl_q;
  assign scl_fall  = ~pins_s.scl & scl_q;
  assign bus_start = pins_s.scl & scl_q & sda_q & ~pins_s.sda;
  assign bus_stop  = pins_s.scl & scl_q & ~sda_q & pins_s.sda;
  // a recheck end landing in the cycle the supply drops must not sample the battery
  assign bat_check = vcc_rise | (bat_done & pins_s.vcc_ok);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      vcc_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      vcc_q <= pins_s.vcc_ok;
      scl_q <= pins_s.scl;
      sda_q <= pins_s.sda;
    end
  end

  // deselect length picked at the supply rise
  assign desel_val = ctrl.tr ? DESEL_W'(TREC_FAST_CYC) : (ctrl.halt ? TREC_HALT_CYC_P : TREC_DEF_CYC_P);

  rtcsf_timer #(.W(DESEL_W)) u_desel (
    .clk      (mclk),
    .resetn   (resetn),
    .load     (vcc_rise),
    .load_val (desel_val),
    .abort    (~pins_s.vcc_ok),
    .busy     (desel_busy),
    .done     ()
  );

  // the recheck timer is dropped on battery, so no check can fire there
  rtcsf_timer #(.W(BAT_W)) u_bat (
    .clk      (mclk),
    .resetn   (resetn),
    .load     (bat_check),
    .load_val (BAT_CYC_P),
    .abort    (~pins_s.vcc_ok),
    .busy     (),
    .done     (bat_done)
  );

  // reset output low while supply is out and through the recovery time
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_n_oe <= 1'b1;
    end else begin
      rst_n_oe <= ~pins_s.vcc_ok | vcc_rise | desel_busy;
    end
  end

  // open-drain data levels are always low; only the enables move
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sda_out   <= 1'b0;
      irq_n_out <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      sda_out   <= 1'b0;
      irq_n_out <= 1'b0;
      rst_n_out <= 1'b0;
    end
  end

  // battery low: only sampled at a check, cleared only by a passing check
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      battery_low_flag <= 1'b0;
    end else if (bat_check) begin
      battery_low_flag <= pins_s.bat_low;
    end
  end

  // oscillator fail: set wins over a host clear, writing 1 does nothing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      osc_fail_flag <= 1'b1;
    end else if (!pins_s.osc_run || ctrl.halt) begin
      osc_fail_flag <= 1'b1;
    end else if (reg_wr && wr_ptr == REG_FLAGS && !wr_data[BIT_OF]) begin
      osc_fail_flag <= 1'b0;
    end
  end

  // control bits: host writes, then supply-edge clears take priority
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_INIT;
    end else begin
      if (reg_wr) begin
        unique case (wr_ptr)
          REG_HALT: begin
            ctrl.halt    <= wr_data[BIT_HALT];
            ctrl.halt_lo <= wr_data[6:0];
          end
          REG_HOURS: begin
            ctrl.tr       <= wr_data[BIT_TR];
            ctrl.hours_lo <= wr_data[6:0];
          end
          REG_CTRL: begin
            ctrl.pin_level <= wr_data[BIT_OUT];
            ctrl.ft        <= wr_data[BIT_FT];
          end
          REG_WDOG:   ctrl.wdog <= wr_data;
          REG_ALARM: begin
            ctrl.afe  <= wr_data[BIT_AFE];
            ctrl.sq_wave_en <= wr_data[BIT_SQ_WAVE_EN];
            ctrl.abe  <= wr_data[BIT_ABE];
          end
          REG_FREEZE: ctrl.ht <= wr_data[BIT_HT];
          REG_IRQCFG: begin
            ctrl.osc_fail_irq_en  <= wr_data[BIT_OSC_FAIL_IRQ_EN];
            ctrl.sq_wave_open_drain <= wr_data[BIT_SQ_WAVE_OPEN_DRAIN];
            ctrl.pf_out_open_drain  <= wr_data[BIT_PF_OUT_OPEN_DRAIN];
          end
          REG_TAMPER: begin
            ctrl.f32k <= wr_data[BIT_F32K];
            ctrl.threshold_select  <= wr_data[BIT_THS];
            ctrl.teb  <= wr_data[5:4];
            ctrl.tie  <= wr_data[3:2];
            ctrl.tclr <= wr_data[1:0];
          end
          REG_TAMPER2: ctrl.tmisc <= wr_data;
          default: ; // flags, serial number and holes take no control write
        endcase
      end
      if (vcc_rise) begin
        ctrl.osc_fail_irq_en <= 1'b0;
        ctrl.afe  <= 1'b0;
        ctrl.abe  <= 1'b0;
        ctrl.sq_wave_en <= 1'b0;
        ctrl.tie  <= 2'h0;
      end
      if (vcc_fall) begin
        ctrl.ht   <= ~|ctrl.teb;
        ctrl.ft   <= 1'b0;
        ctrl.wdog <= 8'h00;
      end
    end
  end

  // interrupt pin: enabled sources, else the plain output level
  assign any_src = ctrl.osc_fail_irq_en | ctrl.afe | (|ctrl.tie) | (|ctrl.wdog);
  assign irq_src = ctrl.osc_fail_irq_en & osc_fail_flag & ~(rst_n_oe & pins_s.vcc_ok);
  assign pin_low = any_src ? irq_src : ~ctrl.pin_level;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_oe <= pin_low & (pins_s.vcc_ok | ctrl.abe);
    end
  end

  // register read view; unmapped offsets read as zero
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      REG_HALT:    v = {ctrl.halt, ctrl.halt_lo};
      REG_HOURS:   v = {ctrl.tr, ctrl.hours_lo};
      REG_CTRL:    v = {ctrl.pin_level, ctrl.ft, 6'h00};
      REG_WDOG:    v = ctrl.wdog;
      REG_ALARM:   v = {ctrl.afe, ctrl.sq_wave_en, ctrl.abe, 5'h00};
      REG_FREEZE:  v = {1'b0, ctrl.ht, 6'h00};
      REG_FLAGS:   v = {3'h0, battery_low_flag, 1'b0, osc_fail_flag, 2'h0};
      REG_IRQCFG:  v = {ctrl.osc_fail_irq_en, 5'h00, ctrl.sq_wave_open_drain, ctrl.pf_out_open_drain};
      REG_TAMPER:  v = {ctrl.f32k, ctrl.threshold_select, ctrl.teb, ctrl.tie, ctrl.tclr};
      REG_TAMPER2: v = ctrl.tmisc;
      default: begin
        if (a[7:3] == REG_SERIAL[7:3]) begin
          v = SERIAL[8*(7-int'(a[2:0])) +: 8];
        end
      end
    endcase
    return v;
  endfunction

  // byte at the current pointer; its msb goes out first
  assign rd_now = rd_val(ptr);

  // serial slave: bits taken on scl rise, sda driven after scl fall
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state   <= S_IDLE;
      shreg   <= 8'h00;
      rdreg   <= 8'h00;
      ptr     <= 8'h00;
      bitcnt  <= 3'h0;
      ack_on  <= 1'b0;
      sda_oe  <= 1'b0;
      reg_wr  <= 1'b0;
      wr_ptr  <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      if (bus_start) begin
        state  <= S_DEV;
        bitcnt <= 3'h0;
        ack_on <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: ;
          S_DEV, S_PTR, S_WDAT: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], pins_s.sda};
              bitcnt <= 3'(bitcnt + 3'h1);
              if (bitcnt == 3'h7) begin
                state <= (state == S_DEV) ? S_DEV_ACK : ((state == S_PTR) ? S_PTR_ACK : S_WDAT_ACK);
              end
            end
          end
          S_DEV_ACK: begin
            if (scl_fall && !ack_on) begin
              if (shreg[7:1] == DEV_ADDR && !rst_n_oe) begin
                sda_oe <= 1'b1;
                ack_on <= 1'b1;
              end else begin
                state <= S_IDLE;
              end
            end else if (scl_fall) begin
              ack_on <= 1'b0;
              bitcnt <= 3'h0;
              if (shreg[0]) begin
                rdreg  <= rd_now;
                sda_oe <= ~rd_now[7];
                state  <= S_RDAT;
              end else begin
                sda_oe <= 1'b0;
                state  <= S_PTR;
              end
            end
          end
          S_PTR_ACK, S_WDAT_ACK: begin
            if (scl_fall && !ack_on) begin
              if (rst_n_oe) begin
                state <= S_IDLE;
              end else begin
                sda_oe <= 1'b1;
                ack_on <= 1'b1;
                if (state == S_PTR_ACK) begin
                  ptr <= shreg;
                end else begin
                  reg_wr  <= 1'b1;
                  wr_ptr  <= ptr;
                  wr_data <= shreg;
                end
              end
            end else if (scl_fall) begin
              sda_oe <= 1'b0;
              ack_on <= 1'b0;
              bitcnt <= 3'h0;
              if (state == S_WDAT_ACK) begin
                ptr <= 8'(ptr + 8'h01);
              end
              state <= S_WDAT;
            end
          end
          S_RDAT: begin
            if (scl_rise) begin
              bitcnt <= 3'(bitcnt + 3'h1);
              if (bitcnt == 3'h7) begin
                state <= S_RDAT_ACK;
              end
            end else if (scl_fall) begin
              rdreg  <= {rdreg[6:0], 1'b0};
              sda_oe <= ~rdreg[6];
            end
          end
          S_RDAT_ACK: begin
            if (scl_fall && !ack_on) begin
              sda_oe <= 1'b0;
              ack_on <= 1'b1;
            end else if (scl_rise && ack_on) begin
              if (pins_s.sda) begin
                state  <= S_IDLE; // master nack ends the read
                ack_on <= 1'b0;
              end else begin
                ptr <= 8'(ptr + 8'h01);
              end
            end else if (scl_fall) begin
              ack_on <= 1'b0;
              bitcnt <= 3'h0;
              rdreg  <= rd_now;
              sda_oe <= ~rd_now[7];
              state  <= S_RDAT;
            end
          end
        endcase
      end
    end
  end

  // checks of the supervisory behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_bl_sample; !bat_check |=> $stable(battery_low_flag); endproperty
  a_bl_sample: assert property (p_bl_sample) else $error("battery flag moved outside a check");
  property p_bl_check; bat_check |=> battery_low_flag == $past(pins_s.bat_low); endproperty
  a_bl_check: assert property (p_bl_check) else $error("battery flag not taken at check");
  property p_no_batt_check; !pins_s.vcc_ok |-> !bat_check; endproperty
  a_no_batt_check: assert property (p_no_batt_check) else $error("battery check on backup");
  property p_of_set; !pins_s.osc_run |=> osc_fail_flag; endproperty
  a_of_set: assert property (p_of_set) else $error("osc stop not flagged");
  property p_of_rise; $rose(osc_fail_flag) |-> $past(!pins_s.osc_run || ctrl.halt); endproperty
  a_of_rise: assert property (p_of_rise) else $error("osc flag set without a stop");
  property p_irq_on;
    pins_s.vcc_ok && ctrl.osc_fail_irq_en && osc_fail_flag && !rst_n_oe |=> irq_n_oe;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("osc fail interrupt not driven");
  property p_batt_quiet; !pins_s.vcc_ok && !ctrl.abe |=> !irq_n_oe; endproperty
  a_batt_quiet: assert property (p_batt_quiet) else $error("pin driven on battery without enable");
  property p_plain_out; pins_s.vcc_ok && !any_src |=> irq_n_oe == !$past(ctrl.pin_level); endproperty
  a_plain_out: assert property (p_plain_out) else $error("pin does not follow level bit");
  property p_desel_hold; vcc_rise |=> rst_n_oe [*8]; endproperty
  a_desel_hold: assert property (p_desel_hold) else $error("deselect ended early");
  property p_no_wr_desel; reg_wr |-> $past(!rst_n_oe); endproperty
  a_no_wr_desel: assert property (p_no_wr_desel) else $error("write taken while deselected");
  property p_rise_clear; vcc_rise |=> !ctrl.osc_fail_irq_en && !ctrl.abe && !ctrl.afe && ctrl.tie == 2'h0; endproperty
  a_rise_clear: assert property (p_rise_clear) else $error("enables kept over power-up");
  property p_tamper_ht; vcc_fall && (|ctrl.teb) |=> !ctrl.ht; endproperty
  a_tamper_ht: assert property (p_tamper_ht) else $error("freeze flag set with tamper on");
  property p_of_keep;
    osc_fail_flag && !(reg_wr && wr_ptr == REG_FLAGS && !wr_data[BIT_OF]) |=> osc_fail_flag;
  endproperty
  a_of_keep: assert property (p_of_keep) else $error("osc flag lost without a write");

  c_power_up: cover property (vcc_rise ##1 rst_n_oe [*4]);
  c_irq: cover property ($rose(irq_n_oe) && ctrl.osc_fail_irq_en);
  c_flag_clear: cover property ($fell(osc_fail_flag));
  c_bl_set: cover property ($rose(battery_low_flag));
endmodule : rtcsf_top
`default_nettype wire

// [rtcsf_host.sv]
// two-wire bus master model driving the flags block
`timescale 1ns/1ps
`default_nettype none
module rtcsf_host
  import rtcsf_pkg::*;
(
  // clock and wire level
  input  wire logic mclk,
  input  wire logic sda,
  // scl level and sda pull-down
  output logic      scl,
  output logic      pull
);
  logic ack; // ninth bit as seen, 0 when acked
  initial scl = 1'h1;
  initial pull = 1'h0;
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  // one phase, 320 ns or 480 ns with e: sda moves mid-low, sampled late in the high half
  task automatic ph(input logic a, input logic e, input logic b, input logic c, output logic r);
    wt(2);
    pull = a;
    wt(2);
    scl = 1'h1;
    wt(4);
    r = sda;
    if (e) begin
      pull = b;
      wt(4);
    end
    scl = c; // scl stands high only between frames
  endtask : ph
  // ninth bit always released, so a read ends with a nack
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) ph(~d[i], 1'h0, 1'h0, 1'h0, q[i]);
    ph(1'h0, 1'h0, 1'h0, 1'h0, ack);
  endtask : byte_x
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    ph(1'h0, 1'h1, 1'h1, 1'h0, q[0]);
    byte_x({DEV_ADDR, 1'h0}, q);
    byte_x(p, q);
    byte_x(d, q);
    ph(1'h1, 1'h1, 1'h0, 1'h1, q[0]);
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    ph(1'h0, 1'h1, 1'h1, 1'h0, q[0]);
    byte_x({DEV_ADDR, 1'h0}, q);
    byte_x(p, q);
    ph(1'h0, 1'h1, 1'h1, 1'h0, q[0]);
    byte_x({DEV_ADDR, 1'h1}, q);
    byte_x(8'hff, d);
    ph(1'h1, 1'h1, 1'h0, 1'h1, q[0]);
  endtask : rd
endmodule : rtcsf_host
`default_nettype wire

// [rtcsf_top_tb.sv]
// self-checking bench for the supervisor status flags block
`timescale 1ns/1ps
`default_nettype none
module rtcsf_top_tb;
  import rtcsf_pkg::*;
  typedef struct packed {logic w; logic [7:0] p, d, e; logic i;} rtcsf_row_t;
  // write flag, offset, data, read back, interrupt pin pulled
  localparam rtcsf_row_t ROWS [26] = '{
    '{1'h0,8'h04,8'h00,8'h00,1'h0}, '{1'h0,8'h01,8'h00,8'h00,1'h0}, '{1'h0,8'h08,8'h00,8'h80,1'h0},
    '{1'h0,8'h0f,8'h00,8'h04,1'h0}, '{1'h0,8'h13,8'h00,8'h03,1'h0}, '{1'h0,8'h14,8'h00,8'h80,1'h0},
    '{1'h0,8'h0c,8'h00,8'h40,1'h0}, '{1'h1,8'h18,8'hff,SERIAL_DEF[63:56],1'h0},
    '{1'h0,8'h1f,8'h00,SERIAL_DEF[7:0],1'h0}, '{1'h0,8'h30,8'h00,8'h00,1'h0},
    '{1'h1,8'h0f,8'h14,8'h04,1'h0}, '{1'h1,8'h08,8'h00,8'h00,1'h1}, '{1'h1,8'h08,8'h80,8'h80,1'h0},
    '{1'h1,8'h13,8'h83,8'h83,1'h1}, '{1'h0,8'h0f,8'h00,8'h04,1'h1}, '{1'h1,8'h0f,8'h00,8'h00,1'h0},
    '{1'h1,8'h01,8'h80,8'h80,1'h1}, '{1'h0,8'h0f,8'h00,8'h04,1'h1}, '{1'h1,8'h13,8'h03,8'h03,1'h0},
    '{1'h1,8'h04,8'h80,8'h80,1'h0}, '{1'h1,8'h04,8'h00,8'h00,1'h0}, '{1'h1,8'h13,8'h83,8'h83,1'h1},
    '{1'h1,8'h0a,8'he0,8'he0,1'h1}, '{1'h1,8'h09,8'hff,8'hff,1'h1}, '{1'h1,8'h0c,8'h00,8'h00,1'h1},
    '{1'h1,8'h14,8'hbc,8'hbc,1'h1}};
  logic       mclk, resetn, vcc, bat, osc, scl, pull, sda_oe, irq_oe, rst_oe;
  logic [7:0] q;
  logic       so, io, ro;
  int         num_errors, tests_run, n, cyc;
  wire logic  sda = ~(sda_oe | pull); // pulled-up wire
  rtcsf_top #(.TREC_DEF_CYC_P(22'h0000c8), .TREC_HALT_CYC_P(22'h000064), .BAT_CYC_P(42'h7d0)) DUT (
    .mclk(mclk), .resetn(resetn), .vcc_ok_pin(vcc), .bat_low_pin(bat), .osc_run_pin(osc), .scl_pin(scl),
    .sda_in(sda), .sda_out(so), .sda_oe(sda_oe), .irq_n_out(io), .irq_n_oe(irq_oe), .rst_n_out(ro), .rst_n_oe(rst_oe));
  rtcsf_host host (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    host.rd(p, q);
    chk(q, e);
  endtask : rdc
  // cycles until the reset output lets go; running out ends the run
  task automatic desel(input int lo, input int hi);
    n = 0;
    while (rst_oe !== 1'h0 && n < hi) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(n >= lo && n < hi), 8'h01);
    if (n >= hi) summarize();
  endtask : desel
  // 25 MHz clock
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // cycles since release, to keep reads clear of battery check instants
  always @(negedge mclk) cyc <= resetn ? cyc + 1 : 0;
  initial begin
    resetn = 1'h0;
    vcc = 1'h1;
    bat = 1'h0;
    osc = 1'h1;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(negedge mclk);
    chk({5'h00, sda_oe, rst_oe, irq_oe}, 8'h02);
    resetn = 1'h1;
    // an address sent while deselected must get no ack
    fork
      desel(200, 212);
      begin
        host.ph(1'h0, 1'h1, 1'h1, 1'h0, q[0]);
        host.byte_x({DEV_ADDR, 1'h0}, q);
        chk({7'h00, host.ack}, 8'h01);
        host.ph(1'h1, 1'h1, 1'h0, 1'h1, q[0]);
      end
    join
    // osc runs from the start, so the flag clear in the rows is legal
    foreach (ROWS[k]) begin
      if (ROWS[k].w) host.wr(ROWS[k].p, ROWS[k].d);
      rdc(ROWS[k].p, ROWS[k].e);
      chk({7'h00, irq_oe}, {7'h00, ROWS[k].i});
    end
    while (cyc % 2000 != 100) @(negedge mclk);
    bat = 1'h1;
    rdc(REG_FLAGS, 8'h04);
    repeat (2000) @(negedge mclk);
    rdc(REG_FLAGS, 8'h14);
    bat = 1'h0;
    rdc(REG_FLAGS, 8'h14);
    vcc = 1'h0;
    repeat (20) @(negedge mclk);
    chk({7'h00, irq_oe}, 8'h01);
    vcc = 1'h1;
    desel(100, 112);
    rdc(REG_FLAGS, 8'h04);
    rdc(REG_IRQCFG, 8'h03);
    rdc(REG_ALARM, 8'h00);
    rdc(REG_WDOG, 8'h00);
    rdc(REG_HALT, 8'h80);
    rdc(REG_FREEZE, 8'h00);
    rdc(REG_TAMPER, 8'hb0);
    chk({5'h00, so, io, ro}, 8'h00);
    summarize();
  end
endmodule : rtcsf_top_tb
`default_nettype wire
